// ==== inc/ssp_pkg.sv ====
package ssp_pkg;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned INT_W = 3;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] STD_LIMIT = 4'h1;
  localparam logic [CNT_W-1:0] ENH_LIMIT = 4'h8;
  localparam logic [4:0] WORD_16 = 5'h10;
  localparam logic [4:0] WORD_8 = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_CTL1 = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CTL2 = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_STAT = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_BUF = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_IST = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_IMSK = 3'h5;
  localparam logic [DATA_W-1:0] CTL1_MASK = 16'h1FFF;
  localparam logic [DATA_W-1:0] CTL2_MASK = 16'hE001;
  localparam logic [DATA_W-1:0] REG_RST = 16'h0000;
  localparam int unsigned B1_CLK_DIS = 12;
  localparam int unsigned B1_DOUT_DIS = 11;
  localparam int unsigned B1_WIDTH = 10;
  localparam int unsigned B1_SAMPLE = 9;
  localparam int unsigned B1_EDGE = 8;
  localparam int unsigned B1_SEL_EN = 7;
  localparam int unsigned B1_POL = 6;
  localparam int unsigned B1_MASTER = 5;
  localparam int unsigned B1_SEC_HI = 4;
  localparam int unsigned B1_SEC_LO = 2;
  localparam int unsigned B1_PRI_HI = 1;
  localparam int unsigned B1_PRI_LO = 0;
  localparam int unsigned B2_FRM_EN = 15;
  localparam int unsigned B2_FRM_IN = 14;
  localparam int unsigned B2_FRM_POL = 13;
  localparam int unsigned B2_ENH = 0;
  localparam int unsigned BS_EN = 15;
  localparam int unsigned BS_ROV = 6;
  localparam int unsigned BS_BUSY = 4;
  localparam int unsigned BS_TXF = 1;
  localparam int unsigned BS_RXNE = 0;
  localparam int unsigned I_DONE = 0;
  localparam int unsigned I_RX = 1;
  localparam int unsigned I_ROV = 2;
  localparam logic [1:0] PRI_MAX = 2'h3;
  localparam logic [3:0] SEC_BASE = 4'h8;
  localparam int unsigned DIV_W = 10;
  localparam logic [DIV_W-1:0] DIV_MIN = 10'h002;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} ssp_state_t;
endpackage : ssp_pkg

// ==== design/ssp_fifo.sv ====
`timescale 1ns/100ps
module ssp_fifo
  import ssp_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
)(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic push_in,
  input wire logic [WIDTH-1:0] push_data_in,
  input wire logic pop_in,
  output logic [WIDTH-1:0] head_out,
  output logic [CNT_W-1:0] count_out
);
  localparam int unsigned PW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << PW) != DEPTH || DEPTH >= (1 << CNT_W))
  begin : g_bad_depth
    $error("fifo depth must be a power of two that fits the count");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q, rd_ptr_q;
  // Head is registered, so it trails a pointer move by one cycle
  always_ff @(posedge clk_in)
  begin
    if (push_in) mem_q[wr_ptr_q] <= push_data_in;
    head_out <= mem_q[rd_ptr_q];
  end
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_out <= '0;
    end
    else
    begin
      if (push_in) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop_in) rd_ptr_q <= rd_ptr_q + 1'b1;
      count_out <= count_out + CNT_W'(push_in) - CNT_W'(pop_in);
    end
  end
endmodule : ssp_fifo

// ==== design/ssp_clkdiv.sv ====
`timescale 1ns/100ps
module ssp_clkdiv
  import ssp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic [1:0] pri_in,
  input wire logic [2:0] sec_in,
  output logic lead_out,
  output logic trail_out
);
  logic [DIV_W-1:0] cnt_q, ps, ps_raw;
  always_comb
  begin
    // Primary 1/4/16/64 for codes 3..0, secondary 8 minus code
    ps_raw = DIV_W'(SEC_BASE - {1'b0, sec_in}) << {(PRI_MAX - pri_in), 1'b0};
    // Divide by one cannot make two edges per period, so it runs as two
    ps = (ps_raw < DIV_MIN) ? DIV_MIN : ps_raw;
  end
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_q <= '0;
      lead_out <= 1'b0;
      trail_out <= 1'b0;
    end
    else if (!run_in)
    begin
      cnt_q <= '0;
      lead_out <= 1'b0;
      trail_out <= 1'b0;
    end
    else
    begin
      lead_out <= (cnt_q == '0);
      trail_out <= (cnt_q == (ps >> 1));
      cnt_q <= (cnt_q == ps - 1'b1) ? '0 : cnt_q + 1'b1;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  lead_apart_a: assert property (lead_out |=> !lead_out) else $error("lead twice");
  edge_split_a: assert property (!(lead_out && trail_out)) else $error("edges clash");
endmodule : ssp_clkdiv

// ==== design/ssp_port.sv ====
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module ssp_port
  import ssp_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  output logic irq_out,
  input wire logic serial_in_pin_in,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe_out,
  input wire logic shift_clock_pin_in,
  output logic shift_clock_pin_out,
  output logic shift_clock_pin_oe_out,
  input wire logic select_or_frame_pin_in,
  output logic select_or_frame_pin_out,
  output logic select_or_frame_pin_oe_out
);
  logic [DATA_W-1:0] ctl1_q, ctl2_q;
  logic en_q, rov_q;
  logic [INT_W-1:0] ist_q, imsk_q, ev_set;
  ssp_state_t state_q;
  logic [DATA_W-1:0] tx_sh_q, rx_sh_q, tx_head, rx_head, stat_w;
  logic [4:0] bit_cnt_q, cnt_nx, width;
  logic first_q, sck_q, sdo_q, frm_q, sck_prev_q, tx_seen_q;
  logic [CNT_W-1:0] tx_cnt, rx_cnt, limit;
  logic master, wide, late_smp, clk_pol, framed, frm_in, frm_pol, edge_sel, sel_en;
  logic dout_dis, clk_dis, enh;
  logic wr_ctl1, wr_ctl2, wr_stat, wr_buf, wr_ist, wr_imsk, rd_buf;
  logic tx_push, tx_pop, rx_push, rx_pop, rx_full, tx_full;
  logic div_lead, div_trail, s_rise, s_fall, lead, trail, out_edge, smp_edge;
  logic sel_ok, sync_on, start, finish, abort, load;

  assign master = ctl1_q[B1_MASTER];
  assign wide = ctl1_q[B1_WIDTH];
  // Late sampling is honoured only in master role
  assign late_smp = master & ctl1_q[B1_SAMPLE];
  assign clk_pol = ctl1_q[B1_POL];
  assign framed = ctl2_q[B2_FRM_EN];
  assign frm_in = ctl2_q[B2_FRM_IN];
  assign frm_pol = ctl2_q[B2_FRM_POL];
  assign edge_sel = ctl1_q[B1_EDGE] & ~framed;
  assign sel_en = ctl1_q[B1_SEL_EN];
  assign dout_dis = ctl1_q[B1_DOUT_DIS];
  assign clk_dis = ctl1_q[B1_CLK_DIS];
  assign enh = ctl2_q[B2_ENH];
  assign width = wide ? WORD_16 : WORD_8;
  assign limit = enh ? ENH_LIMIT : STD_LIMIT;

  assign wr_ctl1 = reg_wr_in && reg_addr_in == OFS_CTL1;
  assign wr_ctl2 = reg_wr_in && reg_addr_in == OFS_CTL2;
  assign wr_stat = reg_wr_in && reg_addr_in == OFS_STAT;
  assign wr_buf = reg_wr_in && reg_addr_in == OFS_BUF;
  assign wr_ist = reg_wr_in && reg_addr_in == OFS_IST;
  assign wr_imsk = reg_wr_in && reg_addr_in == OFS_IMSK;
  assign rd_buf = reg_rd_in && reg_addr_in == OFS_BUF;

  assign tx_full = tx_cnt >= limit;
  assign rx_full = rx_cnt >= limit;
  // A write to a full transmit buffer is dropped
  assign tx_push = wr_buf && !tx_full;
  assign rx_pop = rd_buf && rx_cnt != '0;

  ssp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_in(sys_clk_in),
    .rst_in(rst_in),
    .push_in(tx_push),
    .push_data_in(reg_wdata_in),
    .pop_in(tx_pop),
    .head_out(tx_head),
    .count_out(tx_cnt)
  );
  ssp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_in(sys_clk_in),
    .rst_in(rst_in),
    .push_in(rx_push),
    .push_data_in(rx_sh_q),
    .pop_in(rx_pop),
    .head_out(rx_head),
    .count_out(rx_cnt)
  );
  ssp_clkdiv u_div (
    .clk_in(sys_clk_in),
    .rst_in(rst_in),
    .run_in(master && state_q == ST_SHIFT),
    .pri_in(ctl1_q[B1_PRI_HI:B1_PRI_LO]),
    .sec_in(ctl1_q[B1_SEC_HI:B1_SEC_LO]),
    .lead_out(div_lead),
    .trail_out(div_trail)
  );

  // Slave edges come from the pin, taken as synchronous
  assign s_rise = shift_clock_pin_in & ~sck_prev_q;
  assign s_fall = ~shift_clock_pin_in & sck_prev_q;
  assign lead = master ? div_lead : (clk_pol ? s_fall : s_rise);
  assign trail = master ? div_trail : (clk_pol ? s_rise : s_fall);
  assign out_edge = edge_sel ? trail : lead;
  assign smp_edge = edge_sel ? (late_smp ? trail : lead) : trail;
  assign sync_on = select_or_frame_pin_in == frm_pol;
  // Select is active low; unframed slaves ignore it unless enabled
  assign sel_ok = framed || !sel_en || !select_or_frame_pin_in;
  assign cnt_nx = bit_cnt_q + 5'(smp_edge);
  assign finish = state_q == ST_SHIFT && cnt_nx == width && (!master || trail);
  assign abort = state_q == ST_SHIFT && !master && !sel_ok;

  always_comb
  begin
    start = 1'b0;
    if (state_q == ST_IDLE && en_q)
    begin
      if (master)
        start = tx_seen_q && (!framed || !frm_in || sync_on);
      else
        start = sel_ok && (!framed || !frm_in || sync_on);
    end
  end
  // A slave with nothing queued shifts out zeros
  assign load = start && tx_cnt != '0 && tx_seen_q;
  assign tx_pop = load;

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctl1_q <= REG_RST;
      ctl2_q <= REG_RST;
      imsk_q <= '0;
    end
    else
    begin
      if (wr_ctl1) ctl1_q <= reg_wdata_in & CTL1_MASK;
      if (wr_ctl2) ctl2_q <= reg_wdata_in & CTL2_MASK;
      if (wr_imsk) imsk_q <= reg_wdata_in[INT_W-1:0];
    end
  end

  assign rx_push = state_q == ST_DONE && !rx_full;
  assign ev_set[I_DONE] = state_q == ST_DONE;
  assign ev_set[I_RX] = rx_push;
  assign ev_set[I_ROV] = state_q == ST_DONE && rx_full;

  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      en_q <= 1'b0;
      rov_q <= 1'b0;
      ist_q <= '0;
      irq_out <= 1'b0;
    end
    else
    begin
      if (wr_stat) en_q <= reg_wdata_in[BS_EN];
      if (ev_set[I_ROV]) rov_q <= 1'b1;
      else if (wr_stat && !reg_wdata_in[BS_ROV]) rov_q <= 1'b0;
      ist_q <= ev_set | (ist_q & ~(wr_ist ? reg_wdata_in[INT_W-1:0] : '0));
      irq_out <= |(ist_q & imsk_q);
    end
  end

  always_comb
  begin
    stat_w = '0;
    stat_w[BS_EN] = en_q;
    stat_w[BS_ROV] = rov_q;
    stat_w[BS_BUSY] = state_q != ST_IDLE;
    stat_w[BS_TXF] = tx_full;
    stat_w[BS_RXNE] = rx_cnt != '0;
  end

  // Unmapped addresses read as zero
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      reg_rdata_out <= '0;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        OFS_CTL1: reg_rdata_out <= ctl1_q;
        OFS_CTL2: reg_rdata_out <= ctl2_q;
        OFS_STAT: reg_rdata_out <= stat_w;
        OFS_BUF: reg_rdata_out <= rx_head;
        OFS_IST: reg_rdata_out <= DATA_W'(ist_q);
        OFS_IMSK: reg_rdata_out <= DATA_W'(imsk_q);
        default: reg_rdata_out <= '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q <= ST_IDLE;
      tx_sh_q <= '0;
      rx_sh_q <= '0;
      bit_cnt_q <= '0;
      first_q <= 1'b0;
      sdo_q <= 1'b0;
      tx_seen_q <= 1'b0;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      sck_prev_q <= shift_clock_pin_in;
      // Head register lags the count by one cycle
      tx_seen_q <= tx_cnt != '0 && !tx_pop;
      case (state_q)
        ST_IDLE:
        begin
          if (start)
          begin
            state_q <= ST_SHIFT;
            tx_sh_q <= !load ? '0 : (wide ? tx_head : {tx_head[7:0], 8'h00});
            sdo_q <= load && (wide ? tx_head[15] : tx_head[7]);
            bit_cnt_q <= '0;
            first_q <= !edge_sel;
          end
        end
        ST_SHIFT:
        begin
          if (smp_edge)
          begin
            rx_sh_q <= {rx_sh_q[14:0], serial_in_pin_in};
            bit_cnt_q <= cnt_nx;
          end
          if (out_edge && first_q)
            first_q <= 1'b0;
          else if (out_edge)
          begin
            tx_sh_q <= {tx_sh_q[14:0], 1'b0};
            sdo_q <= tx_sh_q[14];
          end
          if (abort || !en_q) state_q <= ST_IDLE;
          else if (finish) state_q <= ST_DONE;
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Master clock idles at the polarity level between words
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sck_q <= 1'b0;
      frm_q <= 1'b0;
    end
    else
    begin
      if (state_q != ST_SHIFT) sck_q <= clk_pol;
      else if (div_lead) sck_q <= ~clk_pol;
      else if (div_trail) sck_q <= clk_pol;
      // Generated sync lasts until the first trailing edge
      if (start) frm_q <= frm_pol;
      else if (state_q != ST_SHIFT || trail) frm_q <= ~frm_pol;
    end
  end

  assign serial_out_pin_out = sdo_q;
  assign shift_clock_pin_out = sck_q;
  assign select_or_frame_pin_out = frm_q;

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      serial_out_pin_oe_out <= 1'b0;
      shift_clock_pin_oe_out <= 1'b0;
      select_or_frame_pin_oe_out <= 1'b0;
    end
    else
    begin
      serial_out_pin_oe_out <= en_q && !dout_dis && (master || sel_ok);
      shift_clock_pin_oe_out <= en_q && master && !clk_dis;
      select_or_frame_pin_oe_out <= en_q && framed && !frm_in;
    end
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  master_start_a: assert property (en_q && master && state_q == ST_IDLE && tx_seen_q
    && !framed |=> state_q == ST_SHIFT) else $error("master did not start");
  idle_clock_a: assert property (state_q == ST_IDLE && master |-> ##1 sck_q == $past(clk_pol))
    else $error("idle clock level wrong");
  clk_free_a: assert property (clk_dis |=> !shift_clock_pin_oe_out)
    else $error("clock pin driven while disabled");
  slave_clk_a: assert property (!master |=> !shift_clock_pin_oe_out)
    else $error("slave drives clock");
  two_pin_a: assert property (dout_dis |=> !serial_out_pin_oe_out)
    else $error("data out driven while disabled");
  word_len_a: assert property (state_q == ST_DONE |-> bit_cnt_q == width)
    else $error("word length wrong");
  std_depth_a: assert property (!enh && $stable(ctl2_q) |-> tx_cnt <= STD_LIMIT)
    else $error("standard buffer over one");
  sel_gate_a: assert property (!master && sel_en && !framed && select_or_frame_pin_in
    && state_q == ST_SHIFT |=> state_q == ST_IDLE) else $error("select ignored");
  frame_edge_a: assert property (framed |-> out_edge == lead)
    else $error("edge select used in framed");
  irq_level_a: assert property (|(ist_q & imsk_q) |=> irq_out)
    else $error("interrupt missing");
  done_cov: cover property (state_q == ST_DONE && master);
  slave_cov: cover property (state_q == ST_DONE && !master);
  rov_cov: cover property (ev_set[I_ROV]);
  frame_cov: cover property (start && framed);
endmodule : ssp_port

// ==== tb/ssp_peer.sv ====
`timescale 1ns/100ps
module ssp_peer (
  input wire logic sclk_in,
  input wire logic pol_in,
  input wire logic mosi_in,
  input wire logic [4:0] bits_in,
  input wire logic [15:0] reply_in,
  output logic miso_out,
  output logic [15:0] got_out
);
  // Three-pin use has no select, so between words the peer shows the next MSB
  int leads = 0;
  int trails = 0;
  logic [15:0] rx_q = 16'h0000;
  initial got_out = 16'h0000;
  always @(reply_in or bits_in)
    if (leads == 0)
      miso_out = reply_in[bits_in-5'h01];
  always @(sclk_in)
  begin
    if (sclk_in !== pol_in)
    begin
      // First leading edge keeps the MSB, later ones move to the next bit
      if (leads != 0)
        miso_out = reply_in[bits_in-leads-1];
      leads++;
    end
    else if (leads != 0)
    begin
      // Trailing edges with no lead before them are idle-level changes, not data
      rx_q = {rx_q[14:0], mosi_in};
      trails++;
      if (trails == bits_in)
      begin
        got_out = rx_q;
        rx_q = 16'h0000;
        leads = 0;
        trails = 0;
        miso_out = reply_in[bits_in-5'h01];
      end
    end
  end
endmodule : ssp_peer

// ==== tb/ssp_port_test.sv ====
`timescale 1ns/100ps
module ssp_port_test;
  import ssp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = 3'h0;
  logic [DATA_W-1:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic irq, dout, dout_oe, sclk, sclk_oe, din;
  logic pol = 1'b0;
  logic [4:0] nbits = 5'h08;
  logic [15:0] reply = 16'h0000;
  logic [15:0] got;
  // Bench drives the clock line when the port does not; it rests at the idle level
  logic ext_clk = 1'b0;
  logic ext_sel = 1'b1;
  wire logic sclk_w = sclk_oe ? sclk : ext_clk;
  int err_total = 0;
  int n_tests = 0;
  int edges = 0;
  time t_prev = 0;
  time t_now = 0;

  ssp_port ssp_port_i (.sys_clk_in(clk), .rst_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .irq_out(irq), .serial_in_pin_in(din), .serial_out_pin_out(dout),
    .serial_out_pin_oe_out(dout_oe), .shift_clock_pin_in(sclk_w),
    .shift_clock_pin_out(sclk), .shift_clock_pin_oe_out(sclk_oe),
    .select_or_frame_pin_in(ext_sel), .select_or_frame_pin_out(),
    .select_or_frame_pin_oe_out());
  ssp_peer ssp_peer_i (.sclk_in(sclk_w), .pol_in(pol), .mosi_in(dout), .bits_in(nbits),
    .reply_in(reply), .miso_out(din), .got_out(got));

  initial forever #50 clk = ~clk;
  always @(posedge sclk_w)
  begin
    edges++;
    t_prev = t_now;
    t_now = $time;
  end

  task automatic close_out;
    $display("mismatches %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_tests++;
    if (seen !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, seen);
      err_total++;
    end
  endtask : chk

  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic wait_done;
    logic [15:0] s;
    int i;
    for (i = 0; i < 300; i++)
    begin
      rd_reg(OFS_IST, s);
      if (s[I_DONE] === 1'b1)
        break;
    end
    if (i == 300)
    begin
      $display("unexpected word done expected 1 seen 0");
      err_total++;
      close_out();
    end
    wr_reg(OFS_IST, 16'h0001);
  endtask : wait_done

  task automatic cfg(input logic [15:0] c1, input logic [15:0] c2, input logic [4:0] nb,
    input logic p);
    wr_reg(OFS_STAT, 16'h0000);
    wr_reg(OFS_CTL1, c1);
    wr_reg(OFS_CTL2, c2);
    nbits <= nb;
    pol <= p;
    ext_clk <= p;
    wr_reg(OFS_STAT, 16'h8000);
    repeat (2) @(posedge clk);
  endtask : cfg

  task automatic xfer(input logic [15:0] tx, input logic [15:0] rep);
    reply <= rep;
    wr_reg(OFS_BUF, tx);
    wait_done();
  endtask : xfer

  task automatic t_regs;
    logic [15:0] d;
    rd_reg(OFS_CTL1, d);
    chk("control one reset", 16'h0000, d);
    wr_reg(OFS_CTL1, 16'hFFFF);
    rd_reg(OFS_CTL1, d);
    chk("control one", 16'h1FFF, d);
    wr_reg(OFS_CTL2, 16'hFFFF);
    rd_reg(OFS_CTL2, d);
    chk("control two", 16'hE001, d);
    rd_reg(3'h7, d);
    chk("unmapped read", 16'h0000, d);
    wr_reg(OFS_CTL2, 16'h0000);
  endtask : t_regs

  task automatic t_master8;
    logic [15:0] d;
    int e0;
    cfg(16'h003E, 16'h0000, 5'h08, 1'b0);
    chk("idle clock low", 16'h0000, {15'h0000, sclk_w});
    chk("clock pin driven", 16'h0001, {15'h0000, sclk_oe});
    e0 = edges;
    xfer(16'h00A5, 16'h003C);
    chk("byte clock edges", 16'h0008, 16'(edges - e0));
    chk("sent byte", 16'h00A5, got);
    chk("period 4x1", 16'h0190, 16'(t_now - t_prev));
    chk("masked irq", 16'h0000, {15'h0000, irq});
    rd_reg(OFS_BUF, d);
    chk("received byte", 16'h003C, {8'h00, d[7:0]});
    wr_reg(OFS_IST, 16'h0007);
  endtask : t_master8

  task automatic t_word16;
    logic [15:0] d;
    int e0;
    cfg(16'h047A, 16'h0000, 5'h10, 1'b1);
    chk("idle clock high", 16'h0001, {15'h0000, sclk_w});
    wr_reg(OFS_IMSK, 16'h0002);
    e0 = edges;
    xfer(16'hC3A5, 16'h5AF0);
    chk("word clock edges", 16'h0010, 16'(edges - e0));
    chk("sent word", 16'hC3A5, got);
    chk("period 4x2", 16'h0320, 16'(t_now - t_prev));
    chk("irq raised", 16'h0001, {15'h0000, irq});
    rd_reg(OFS_BUF, d);
    chk("received word", 16'h5AF0, d);
    wr_reg(OFS_IST, 16'h0002);
    @(posedge clk);
    #1 chk("irq cleared", 16'h0000, {15'h0000, irq});
    wr_reg(OFS_IMSK, 16'h0000);
    wr_reg(OFS_IST, 16'h0007);
  endtask : t_word16

  task automatic t_fifo;
    logic [15:0] d;
    int e0;
    cfg(16'h003E, 16'h0001, 5'h08, 1'b0);
    e0 = edges;
    reply <= 16'h0081;
    wr_reg(OFS_BUF, 16'h0011);
    wr_reg(OFS_BUF, 16'h0022);
    wr_reg(OFS_BUF, 16'h0033);
    repeat (3) wait_done();
    chk("queued clock edges", 16'h0018, 16'(edges - e0));
    chk("last queued byte", 16'h0033, got);
    rd_reg(OFS_STAT, d);
    chk("no overflow", 16'h0000, {15'h0000, d[BS_ROV]});
    repeat (3)
    begin
      rd_reg(OFS_BUF, d);
      chk("queued reply", 16'h0081, {8'h00, d[7:0]});
    end
    wr_reg(OFS_IST, 16'h0007);
  endtask : t_fifo

  task automatic t_pins;
    logic [15:0] d;
    cfg(16'h183E, 16'h0000, 5'h08, 1'b0);
    reply <= 16'h0000;
    wr_reg(OFS_BUF, 16'h0055);
    repeat (4) @(posedge clk);
    #1 chk("clock pin released", 16'h0000, {15'h0000, sclk_oe});
    chk("data pin released", 16'h0000, {15'h0000, dout_oe});
    wait_done();
    // Second word with the single buffer still full must overflow
    xfer(16'h0066, 16'h0000);
    rd_reg(OFS_STAT, d);
    chk("overflow flag", 16'h0001, {15'h0000, d[BS_ROV]});
    rd_reg(OFS_IST, d);
    chk("overflow event", 16'h0001, {15'h0000, d[I_ROV]});
  endtask : t_pins

  task automatic t_slave;
    logic [15:0] d;
    wr_reg(OFS_IST, 16'h0007);
    // Draining the receive side empties the buffer before slave setup
    rd_reg(OFS_BUF, d);
    rd_reg(OFS_STAT, d);
    chk("buffers empty", 16'h0000, {14'h0000, d[BS_TXF], d[BS_RXNE]});
    cfg(16'h0180, 16'h0000, 5'h08, 1'b0);
    reply <= 16'h00C3;
    wr_reg(OFS_BUF, 16'h0096);
    repeat (2) @(posedge clk);
    #1 chk("deselected data pin", 16'h0000, {15'h0000, dout_oe});
    chk("slave clock pin", 16'h0000, {15'h0000, sclk_oe});
    @(posedge clk);
    ext_sel <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("selected data pin", 16'h0001, {15'h0000, dout_oe});
    // Two system clocks per half period keep the last bit on the pin for the peer
    repeat (16)
    begin
      @(posedge clk);
      ext_clk <= ~ext_clk;
      @(posedge clk);
    end
    @(posedge clk);
    ext_sel <= 1'b1;
    wait_done();
    chk("slave sent byte", 16'h0096, got);
    rd_reg(OFS_BUF, d);
    chk("slave received byte", 16'h00C3, {8'h00, d[7:0]});
  endtask : t_slave

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_master8();
    t_word16();
    t_fifo();
    t_pins();
    t_slave();
    close_out();
  end
endmodule : ssp_port_test
